// [dcr_pkg.sv]
// shared constants, register map and state types of the daisy chain requester
package dcr_pkg;
  localparam int NUM_SRC = 4;
  localparam int IDX_W = 2;
  // register byte addresses
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SRC_EN = 8'h04;
  localparam logic [7:0] OFF_SRC_STAT = 8'h08;
  localparam logic [7:0] OFF_POLL = 8'h0c;
  localparam logic [7:0] OFF_VECTOR = 8'h10;
  localparam logic [7:0] OFF_REQ_CTRL = 8'h14;
  localparam logic [7:0] OFF_SETTLE = 8'h18;
  // control register fields
  localparam int CTRL_MASTER_EN = 0;
  localparam int CTRL_LOWER_BLOCK = 1;
  localparam int CTRL_VEC_SUPPRESS = 2;
  localparam int CTRL_AUTO_CLEAR = 3;
  // status register: pending in low nibble, in service next, suspended next
  localparam int STAT_PEND_POS = 0;
  localparam int STAT_IUS_POS = 4;
  localparam int STAT_SUSP_POS = 8;
  // poll register
  localparam int POLL_ANY_POS = 7;
  // request control fields
  localparam int REQ_BUS_WANT = 0;
  localparam int REQ_RES_WANT = 1;
  localparam int REQ_BUS_OWNED = 4;
  localparam int REQ_RES_OWNED = 5;
  localparam int REQ_RES_DENIED = 6;
  // reset values
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [NUM_SRC-1:0] SRC_EN_RESET = 4'h0;
  localparam logic [7:0] VECTOR_RESET = 8'h00;
  localparam logic [7:0] SETTLE_RESET = 8'h04;
  // claim line must stand high this many cycles before a bus claim
  localparam logic [1:0] BUS_IDLE_CYCLES = 2'h2;

  typedef enum logic [3:0] {
    BUS_IDLE = 4'h1,
    BUS_CLAIM = 4'h2,
    BUS_OWN = 4'h4,
    BUS_DONE = 4'h8
  } dcr_bus_e_t;

  typedef enum logic [2:0] {
    RES_IDLE = 3'h1,
    RES_SETTLE = 3'h2,
    RES_OWN = 3'h4
  } dcr_res_e_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dcr_apb_req_t;

  typedef struct packed {
    logic masterEnable;
    logic lowerChainBlock;
    logic vectorSuppress;
    logic autoClear;
    logic [NUM_SRC-1:0] srcEnable;
    logic [NUM_SRC-1:0] enLive;
    logic [NUM_SRC-1:0] pending;
    logic [NUM_SRC-1:0] inService;
    logic [7:0] vectorBase;
    logic [7:0] vecData;
    logic vecOe;
    logic asPrev;
    logic dsPrev;
    logic ackLatched;
    logic busWant;
    logic resWant;
    dcr_bus_e_t busState;
    logic [1:0] highCnt;
    dcr_res_e_t resState;
    logic [7:0] settleLoad;
    logic [7:0] settleCnt;
    logic resDenied;
    logic [31:0] prdata;
    logic pslverr;
  } dcr_state_t;
endpackage

// [dcr_requester.sv]
// daisy chain interrupt, bus and resource request logic with an APB register file
//
// Overview of operation
// - a detected service condition sets that source's pending flag
// - no request while a higher device in service holds priority_in low
// - acknowledge ending with this source selected sets in-service; pending optionally cleared
// - acknowledge selecting a higher device leaves in-service and pending unchanged
// - a CPU I/O write to the source clears its pending flag
// - clearing in-service ends service; new conditions may set pending anytime
// - in service with priority_in low counts as suspended
// - disabled source never requests; disabled and in service blocks lower sources
// - enable changes apply in every state except during acknowledge; master_enable changes apply during acknowledge too
// - master_enable low acts as every source enable low
// - lower_chain_block forces priority_out low, source states untouched
// - one readable register shows any pending interrupt and its source
// - bus_claim_n pulled low only after two cycles high
// - idle requester passes grant chain, requesting one holds grant_chain_out high
// - bus owned when grant_chain_in low; release claim and pass chain when done
// - the resource has no default owner; acquire before use
// - start resource request only with claim line high, by pulling it low
// - idle device passes resource chain, requester forces resource_chain_out high
// - after settling, own if resource_chain_in low else release and retry later
// - holder releases the resource by letting resource_claim_n go high
// - request only if pending, enabled, master enabled, not in service, chain high, no ack
// - selected source drives vector on low data byte at data strobe fall unless suppressed
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
module dcr_requester (
  input wire logic clk,
  input wire logic rst_n,
  input wire dcr_pkg::dcr_apb_req_t apbReq,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [dcr_pkg::NUM_SRC-1:0] srcEvent,
  input wire logic addrStrobeN,
  input wire logic dataStrobeN,
  input wire logic irqAcknowledgeN,
  input wire logic priorityIn,
  output logic priorityOut,
  output logic irqRequestOut,
  output logic irqRequestOe,
  output logic [7:0] vectorOut,
  output logic vectorOe,
  input wire logic busClaimIn,
  output logic busClaimOut,
  output logic busClaimOe,
  input wire logic grantChainIn,
  output logic grantChainOut,
  input wire logic resourceClaimSense,
  output logic resourceClaimOut,
  output logic resourceClaimOe,
  input wire logic resourceChainIn,
  output logic resourceChainOut
);
  localparam int N = dcr_pkg::NUM_SRC;

  dcr_pkg::dcr_state_t st;
  dcr_pkg::dcr_state_t next_st;

  // daisy chain taps and per source qualifiers
  logic [N:0] chain;
  logic [N-1:0] effEnable;
  logic [N-1:0] canRequest;
  logic [N-1:0] selected;
  logic [dcr_pkg::IDX_W-1:0] selIdx;
  logic [dcr_pkg::IDX_W-1:0] pollIdx;

  // strobe edges and bus decodes
  logic asRise;
  logic dsFall;
  logic wrAccess;
  logic setupRead;
  logic busActive;
  logic resActive;

  // interrupt daisy chain through the sources, highest priority at index 0
  always_comb begin
    chain[0] = priorityIn;
    for (int i = 0; i < N; i++) begin
      effEnable[i] = st.enLive[i] & st.masterEnable;
      if (st.ackLatched) begin
        // during acknowledge an enabled pending source or a serviced source blocks the chain
        chain[i+1] = chain[i] & ~((st.pending[i] & effEnable[i]) | st.inService[i]);
      end else begin
        // in service blocks lower sources even with enable low
        chain[i+1] = chain[i] & ~st.inService[i];
      end
      canRequest[i] = st.pending[i] & effEnable[i] & ~st.inService[i] & chain[i]
        & ~st.ackLatched;
      selected[i] = st.pending[i] & effEnable[i] & ~st.inService[i] & chain[i];
    end
  end

  // source picked at data strobe fall, lowest index wins
  always_comb begin
    selIdx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (selected[i]) begin
        selIdx = dcr_pkg::IDX_W'(i);
      end
    end
  end

  // poll report: highest priority pending source
  always_comb begin
    // masked sources still show, since polling runs with interrupts turned off
    pollIdx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (st.pending[i]) begin
        pollIdx = dcr_pkg::IDX_W'(i);
      end
    end
  end

  // strobe edges from registered copies; APB writes land in access, reads fetch in setup
  assign asRise = ~st.asPrev & addrStrobeN;
  assign dsFall = st.dsPrev & ~dataStrobeN;
  assign wrAccess = apbReq.psel & apbReq.penable & apbReq.pwrite;
  assign setupRead = apbReq.psel & ~apbReq.penable;
  assign busActive = (st.busState == dcr_pkg::BUS_CLAIM) | (st.busState == dcr_pkg::BUS_OWN);
  assign resActive = (st.resState == dcr_pkg::RES_SETTLE) | (st.resState == dcr_pkg::RES_OWN);

  // next state of everything
  always_comb begin
    next_st = st;
    next_st.asPrev = addrStrobeN;
    next_st.dsPrev = dataStrobeN;

    // acknowledge is known from the acknowledge line at the address strobe rise
    if (asRise) begin
      next_st.ackLatched = ~irqAcknowledgeN;
    end

    // enable copies freeze while an acknowledge runs
    // a write made during acknowledge takes hold once the acknowledge ends
    if (!st.ackLatched) begin
      next_st.enLive = st.srcEnable;
    end

    // register writes; clears first so that hardware sets below win
    if (wrAccess) begin
      case (apbReq.paddr)
        dcr_pkg::OFF_CTRL: begin
          next_st.masterEnable = apbReq.pwdata[dcr_pkg::CTRL_MASTER_EN];
          next_st.lowerChainBlock = apbReq.pwdata[dcr_pkg::CTRL_LOWER_BLOCK];
          next_st.vectorSuppress = apbReq.pwdata[dcr_pkg::CTRL_VEC_SUPPRESS];
          next_st.autoClear = apbReq.pwdata[dcr_pkg::CTRL_AUTO_CLEAR];
        end
        dcr_pkg::OFF_SRC_EN: begin
          next_st.srcEnable = apbReq.pwdata[N-1:0];
        end
        dcr_pkg::OFF_SRC_STAT: begin
          // write one to clear pending and in service bits
          next_st.pending = st.pending & ~apbReq.pwdata[dcr_pkg::STAT_PEND_POS +: N];
          next_st.inService = st.inService & ~apbReq.pwdata[dcr_pkg::STAT_IUS_POS +: N];
        end
        dcr_pkg::OFF_VECTOR: begin
          next_st.vectorBase = apbReq.pwdata[7:0];
        end
        dcr_pkg::OFF_REQ_CTRL: begin
          next_st.busWant = apbReq.pwdata[dcr_pkg::REQ_BUS_WANT];
          next_st.resWant = apbReq.pwdata[dcr_pkg::REQ_RES_WANT];
          // the denied flag is sticky until software writes a one to it
          if (apbReq.pwdata[dcr_pkg::REQ_RES_DENIED]) begin
            next_st.resDenied = 1'b0;
          end
        end
        dcr_pkg::OFF_SETTLE: begin
          next_st.settleLoad = apbReq.pwdata[7:0];
        end
        default: begin
          // writes to unmapped places are dropped
        end
      endcase
    end

    // acknowledge ends with this device's source selected
    if (st.ackLatched && dsFall && (|selected)) begin
      next_st.inService[selIdx] = 1'b1;
      if (st.autoClear) begin
        next_st.pending[selIdx] = 1'b0;
      end
      if (!st.vectorSuppress) begin
        // software owns the upper vector bits, the low bits name the source
        next_st.vecData = {st.vectorBase[7:dcr_pkg::IDX_W], selIdx};
        next_st.vecOe = 1'b1;
      end
    end

    // no selection here leaves every flag as it was
    // vector leaves the bus when the data strobe rises
    if (dataStrobeN) begin
      next_st.vecOe = 1'b0;
    end

    // new conditions set pending and beat any clear
    next_st.pending = next_st.pending | srcEvent;

    // count cycles of the bus claim line standing high
    // it saturates, so a long idle spell never wraps back below the threshold
    if (!busClaimIn) begin
      next_st.highCnt = '0;
    end else if (st.highCnt != dcr_pkg::BUS_IDLE_CYCLES) begin
      next_st.highCnt = st.highCnt + 2'h1;
    end

    // bus requester
    case (st.busState)
      dcr_pkg::BUS_IDLE: begin
        // claim only after the line has stood high long enough
        if (st.busWant && busClaimIn && st.highCnt == dcr_pkg::BUS_IDLE_CYCLES) begin
          next_st.busState = dcr_pkg::BUS_CLAIM;
        end
      end

      dcr_pkg::BUS_CLAIM: begin
        // the CPU answers the claim down the grant chain
        // a wish dropped before the grant still waits for the line to lift
        if (!st.busWant) begin
          next_st.busState = dcr_pkg::BUS_DONE;
        end else if (!grantChainIn) begin
          next_st.busState = dcr_pkg::BUS_OWN;
        end
      end

      dcr_pkg::BUS_OWN: begin
        // the bus stays ours until software drops the wish
        if (!st.busWant) begin
          next_st.busState = dcr_pkg::BUS_DONE;
        end
      end

      dcr_pkg::BUS_DONE: begin
        // wait for the whole claim to lift before a new one
        if (busClaimIn) begin
          next_st.busState = dcr_pkg::BUS_IDLE;
        end
      end
      default: begin
        next_st.busState = dcr_pkg::BUS_IDLE;
      end
    endcase

    // resource requester; nobody owns it until acquired
    case (st.resState)
      dcr_pkg::RES_IDLE: begin
        // start only when the shared claim line is seen high
        if (st.resWant && resourceClaimSense) begin
          next_st.resState = dcr_pkg::RES_SETTLE;
          next_st.settleCnt = st.settleLoad;
        end
      end

      dcr_pkg::RES_SETTLE: begin
        // the chain is sampled only after the whole programmed wait
        if (!st.resWant) begin
          next_st.resState = dcr_pkg::RES_IDLE;
        end else if (st.settleCnt != 8'h00) begin
          next_st.settleCnt = st.settleCnt - 8'h01;
        end else if (!resourceChainIn) begin
          next_st.resState = dcr_pkg::RES_OWN;
        end else begin
          // lost: let go and retry when the line is next high
          next_st.resState = dcr_pkg::RES_IDLE;
          next_st.resDenied = 1'b1;
        end
      end

      dcr_pkg::RES_OWN: begin
        // held until software lets go; no limit on use time is enforced here
        if (!st.resWant) begin
          next_st.resState = dcr_pkg::RES_IDLE;
        end
      end
      default: begin
        next_st.resState = dcr_pkg::RES_IDLE;
      end
    endcase

    // read data prepared in the setup phase so that the access needs no wait
    if (setupRead) begin
      next_st.pslverr = 1'b0;
      next_st.prdata = '0;
      case (apbReq.paddr)
        dcr_pkg::OFF_CTRL: begin
          next_st.prdata[dcr_pkg::CTRL_MASTER_EN] = st.masterEnable;
          next_st.prdata[dcr_pkg::CTRL_LOWER_BLOCK] = st.lowerChainBlock;
          next_st.prdata[dcr_pkg::CTRL_VEC_SUPPRESS] = st.vectorSuppress;
          next_st.prdata[dcr_pkg::CTRL_AUTO_CLEAR] = st.autoClear;
        end
        dcr_pkg::OFF_SRC_EN: begin
          next_st.prdata[N-1:0] = st.srcEnable;
        end
        dcr_pkg::OFF_SRC_STAT: begin
          next_st.prdata[dcr_pkg::STAT_PEND_POS +: N] = st.pending;
          next_st.prdata[dcr_pkg::STAT_IUS_POS +: N] = st.inService;
          // in service with the chain low above it means suspended
          for (int i = 0; i < N; i++) begin
            next_st.prdata[dcr_pkg::STAT_SUSP_POS + i] = st.inService[i] & ~chain[i];
          end
        end
        dcr_pkg::OFF_POLL: begin
          // the index reads zero when nothing is pending, so test the any bit first
          next_st.prdata[dcr_pkg::POLL_ANY_POS] = |st.pending;
          next_st.prdata[dcr_pkg::IDX_W-1:0] = pollIdx;
        end
        dcr_pkg::OFF_VECTOR: begin
          next_st.prdata[7:0] = st.vectorBase;
        end
        dcr_pkg::OFF_REQ_CTRL: begin
          next_st.prdata[dcr_pkg::REQ_BUS_WANT] = st.busWant;
          next_st.prdata[dcr_pkg::REQ_RES_WANT] = st.resWant;
          next_st.prdata[dcr_pkg::REQ_BUS_OWNED] = st.busState == dcr_pkg::BUS_OWN;
          next_st.prdata[dcr_pkg::REQ_RES_OWNED] = st.resState == dcr_pkg::RES_OWN;
          next_st.prdata[dcr_pkg::REQ_RES_DENIED] = st.resDenied;
        end
        dcr_pkg::OFF_SETTLE: begin
          next_st.prdata[7:0] = st.settleLoad;
        end
        default: begin
          // unmapped reads give zero data and an error
          next_st.pslverr = 1'b1;
        end
      endcase
    end
  end

  // state register; pins start released after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // clear everything, then load the control, enable, vector and settle fields from their reset values, plus the non-zero strobe and state defaults
      st <= '0;
      st.masterEnable <= dcr_pkg::CTRL_RESET[dcr_pkg::CTRL_MASTER_EN];
      st.lowerChainBlock <= dcr_pkg::CTRL_RESET[dcr_pkg::CTRL_LOWER_BLOCK];
      st.vectorSuppress <= dcr_pkg::CTRL_RESET[dcr_pkg::CTRL_VEC_SUPPRESS];
      st.autoClear <= dcr_pkg::CTRL_RESET[dcr_pkg::CTRL_AUTO_CLEAR];
      st.srcEnable <= dcr_pkg::SRC_EN_RESET;
      st.enLive <= dcr_pkg::SRC_EN_RESET;
      st.vectorBase <= dcr_pkg::VECTOR_RESET;
      st.asPrev <= 1'b1;
      st.dsPrev <= 1'b1;
      st.busState <= dcr_pkg::BUS_IDLE;
      st.resState <= dcr_pkg::RES_IDLE;
      st.settleLoad <= dcr_pkg::SETTLE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // APB answers in the first access cycle
  assign pready = 1'b1;
  assign prdata = st.prdata;
  assign pslverr = st.pslverr & apbReq.psel & apbReq.penable;

  // interrupt pins; the request is open drain, so only the enable moves
  // the request enable is combinational and drops in the cycle priorityIn falls
  assign irqRequestOut = 1'b0;
  assign irqRequestOe = |canRequest;
  assign priorityOut = chain[N] & ~st.lowerChainBlock;
  assign vectorOut = st.vecData;
  assign vectorOe = st.vecOe;

  // bus claim and grant chain; claim drops as soon as the request ends
  assign busClaimOut = 1'b0;
  assign busClaimOe = busActive;
  assign grantChainOut = busActive ? 1'b1 : grantChainIn;

  // resource claim and chain
  assign resourceClaimOut = 1'b0;
  assign resourceClaimOe = resActive;
  assign resourceChainOut = resActive ? 1'b1 : resourceChainIn;
endmodule

// [dcr_requester_chk.sv]
// concurrent checks on the ports of the daisy chain requester
`timescale 1ns/1ps
module dcr_requester_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic addrStrobeN,
  input wire logic dataStrobeN,
  input wire logic irqAcknowledgeN,
  input wire logic priorityIn,
  input wire logic priorityOut,
  input wire logic irqRequestOe,
  input wire logic vectorOe,
  input wire logic busClaimIn,
  input wire logic busClaimOe,
  input wire logic grantChainIn,
  input wire logic grantChainOut,
  input wire logic resourceClaimSense,
  input wire logic resourceClaimOe,
  input wire logic resourceChainIn,
  input wire logic resourceChainOut
);
  // single clock domain, so one default clock and reset serve all checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_grant_chain: assert property (grantChainOut == (busClaimOe | grantChainIn))
    else $error("grant chain output wrong for claim state");
  chk_claim_idle: assert property (
      $rose(busClaimOe) |-> $past(busClaimIn) && $past(busClaimIn, 2))
    else $error("bus claimed without two idle cycles");
  chk_res_chain: assert property (
      resourceChainOut == (resourceClaimOe | resourceChainIn))
    else $error("resource chain output wrong for claim state");
  chk_res_start: assert property ($rose(resourceClaimOe) |-> $past(resourceClaimSense))
    else $error("resource claimed while claim line low");
  chk_irq_chain: assert property (irqRequestOe |-> priorityIn)
    else $error("interrupt request with chain input low");
  chk_ack_quiet: assert property (
      $rose(addrStrobeN) && !irqAcknowledgeN |-> ##2 !irqRequestOe [*2])
    else $error("interrupt request during acknowledge");
  chk_vec_start: assert property (
      $rose(vectorOe) |-> !$past(dataStrobeN) && !$past(irqAcknowledgeN))
    else $error("vector driven outside acknowledge data strobe");
  chk_vec_release: assert property (
      dataStrobeN && $past(dataStrobeN) && $past(dataStrobeN, 2) |-> !vectorOe)
    else $error("vector still driven after data strobe");
  chk_prio_low: assert property (!priorityIn |-> !priorityOut)
    else $error("priority output high with input low");
endmodule

bind dcr_requester dcr_requester_chk u_chk (.clk, .rst_n, .addrStrobeN, .dataStrobeN,
  .irqAcknowledgeN, .priorityIn, .priorityOut, .irqRequestOe, .vectorOe, .busClaimIn,
  .busClaimOe, .grantChainIn, .grantChainOut, .resourceClaimSense, .resourceClaimOe,
  .resourceChainIn, .resourceChainOut);

// [dcr_far_model.sv]
// far side model: bus cpu grant and a higher neighbour on the resource chain
`timescale 1ns/1ps
module dcr_far_model (
  input wire logic clk,
  input wire logic busClaimOe,
  input wire logic resourceClaimOe,
  input wire logic busHold,
  input wire logic resDeny,
  output logic busClaimIn,
  output logic grantChainIn,
  output logic resourceClaimSense,
  output logic resourceChainIn
);
  // claim lines are pulled up, so a released line reads high; busHold is another claimer
  assign busClaimIn = !(busClaimOe || busHold);
  assign resourceClaimSense = !(resourceClaimOe || resDeny);
  // head of chain passes the claim low unless the higher neighbour blocks it
  assign resourceChainIn = resourceClaimSense | resDeny;
  // cpu grants a cycle after the claim and takes the bus back once the line is high
  initial grantChainIn = 1'b1;
  always @(posedge clk) begin
    grantChainIn <= busClaimIn;
  end
endmodule

// [testbench.sv]
// self-checking bench for the daisy chain requester
`timescale 1ns/1ps
module testbench;
  logic clk, rst_n, pready, pslverr, priorityIn, priorityOut, irqRequestOe, vectorOe, e;
  logic addrStrobeN, dataStrobeN, irqAcknowledgeN, busClaimIn, busClaimOe, grantChainIn;
  logic grantChainOut, resourceClaimSense, resourceClaimOe, resourceChainIn, resourceChainOut;
  logic busHold, resDeny;
  logic [3:0] srcEvent;
  logic [7:0] vectorOut;
  logic [31:0] prdata, q;
  dcr_pkg::dcr_apb_req_t apbReq;
  int mismatches = 0;
  int n_compared = 0;
  dcr_requester dut (.clk, .rst_n, .apbReq, .pready, .prdata, .pslverr, .srcEvent,
    .addrStrobeN, .dataStrobeN, .irqAcknowledgeN, .priorityIn, .priorityOut,
    .irqRequestOut(), .irqRequestOe, .vectorOut, .vectorOe, .busClaimIn, .busClaimOut(),
    .busClaimOe, .grantChainIn, .grantChainOut, .resourceClaimSense, .resourceClaimOut(),
    .resourceClaimOe, .resourceChainIn, .resourceChainOut);
  dcr_far_model far (.clk, .busClaimOe, .resourceClaimOe, .busHold, .resDeny, .busClaimIn,
    .grantChainIn, .resourceClaimSense, .resourceChainIn);
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp(input string s, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      mismatches++;
      $display("Error %s expected %h seen %h", s, x, g);
    end
  endtask
  // a bounded wait that ran out ends the run
  task automatic hung(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      $display("Error wait expected done seen timeout");
      wrap_up();
    end
  endtask
  // one apb transfer; request held until pready is seen at a rising edge, answer taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    hung(n, 16);
    q = prdata;
    e = pslverr;
    apbReq <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string s);
    apb(1'b0, a, 32'h0);
    cmp(s, x, q);
  endtask
  task automatic ev(input logic [3:0] k);
    @(posedge clk);
    srcEvent <= k;
    @(posedge clk);
    srcEvent <= 4'h0;
  endtask
  task automatic waitOe(input logic r);
    int n;
    for (n = 0; n < 20; n++) begin
      @(negedge clk);
      if ((r ? resourceClaimOe : busClaimOe) === 1'b1) break;
    end
    hung(n, 20);
  endtask
  task automatic pollReq(input int b);
    int n;
    for (n = 0; n < 10; n++) begin
      apb(1'b0, dcr_pkg::OFF_REQ_CTRL, 32'h0);
      if (q[b] === 1'b1) break;
    end
    hung(n, 10);
  endtask
  // acknowledge cycle, then a plain address strobe to end the latched acknowledge
  task automatic ack(input logic [7:0] v, input logic oe);
    @(posedge clk);
    addrStrobeN <= 1'b0;
    irqAcknowledgeN <= 1'b0;
    @(posedge clk);
    addrStrobeN <= 1'b1;
    repeat (2) @(posedge clk);
    dataStrobeN <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    cmp("vector enable", {31'h0, oe}, {31'h0, vectorOe});
    if (oe) cmp("vector", {24'h0, v}, {24'h0, vectorOut});
    @(posedge clk);
    dataStrobeN <= 1'b1;
    irqAcknowledgeN <= 1'b1;
    addrStrobeN <= 1'b0;
    @(posedge clk);
    addrStrobeN <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    rst_n = 1'b0;
    apbReq = '0;
    srcEvent = 4'h0;
    addrStrobeN = 1'b1;
    dataStrobeN = 1'b1;
    irqAcknowledgeN = 1'b1;
    priorityIn = 1'b1;
    busHold = 1'b0;
    resDeny = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and an unmapped place
    rd(dcr_pkg::OFF_CTRL, 32'h0, "ctrl");
    rd(dcr_pkg::OFF_SETTLE, 32'h4, "settle");
    rd(8'h1c, 32'h0, "unmapped");
    cmp("slave error", 32'h1, {31'h0, e});
    $display("done: reset");
    // request gating by chain, master enable and source enable
    apb(1'b1, dcr_pkg::OFF_CTRL, 32'h1);
    apb(1'b1, dcr_pkg::OFF_SRC_EN, 32'hf);
    ev(4'h2);
    @(negedge clk);
    cmp("request", 32'h1, {31'h0, irqRequestOe});
    rd(dcr_pkg::OFF_POLL, 32'h81, "poll");
    @(posedge clk);
    priorityIn <= 1'b0;
    @(negedge clk);
    cmp("request", 32'h0, {31'h0, irqRequestOe});
    @(posedge clk);
    priorityIn <= 1'b1;
    apb(1'b1, dcr_pkg::OFF_CTRL, 32'h0);
    @(negedge clk);
    cmp("request", 32'h0, {31'h0, irqRequestOe});
    apb(1'b1, dcr_pkg::OFF_CTRL, 32'h1);
    apb(1'b1, dcr_pkg::OFF_SRC_EN, 32'h0);
    repeat (2) @(negedge clk);
    cmp("request", 32'h0, {31'h0, irqRequestOe});
    apb(1'b1, dcr_pkg::OFF_SRC_EN, 32'hf);
    repeat (2) @(negedge clk);
    cmp("request", 32'h1, {31'h0, irqRequestOe});
    $display("done: request");
    // acknowledge selects source 1, then suspension and clearing
    apb(1'b1, dcr_pkg::OFF_VECTOR, 32'ha0);
    ack(8'ha1, 1'b1);
    rd(dcr_pkg::OFF_SRC_STAT, 32'h22, "status");
    cmp("priority out", 32'h0, {31'h0, priorityOut});
    @(posedge clk);
    priorityIn <= 1'b0;
    rd(dcr_pkg::OFF_SRC_STAT, 32'h222, "status");
    @(posedge clk);
    priorityIn <= 1'b1;
    apb(1'b1, dcr_pkg::OFF_SRC_STAT, 32'h22);
    rd(dcr_pkg::OFF_SRC_STAT, 32'h0, "status");
    cmp("priority out", 32'h1, {31'h0, priorityOut});
    // a higher device takes the acknowledge
    ev(4'h2);
    @(posedge clk);
    priorityIn <= 1'b0;
    ack(8'h0, 1'b0);
    @(posedge clk);
    priorityIn <= 1'b1;
    rd(dcr_pkg::OFF_SRC_STAT, 32'h2, "status");
    // vector suppressed and pending auto cleared, source still selected
    apb(1'b1, dcr_pkg::OFF_CTRL, 32'hd);
    ack(8'h0, 1'b0);
    rd(dcr_pkg::OFF_SRC_STAT, 32'h20, "status");
    apb(1'b1, dcr_pkg::OFF_SRC_STAT, 32'h22);
    apb(1'b1, dcr_pkg::OFF_CTRL, 32'h3);
    @(negedge clk);
    cmp("priority out", 32'h0, {31'h0, priorityOut});
    rd(dcr_pkg::OFF_SRC_STAT, 32'h0, "status");
    $display("done: acknowledge");
    // bus claim held off by another claimer, then owned and released
    @(posedge clk);
    busHold <= 1'b1;
    apb(1'b1, dcr_pkg::OFF_REQ_CTRL, 32'h1);
    repeat (4) @(posedge clk);
    @(negedge clk);
    cmp("bus claim", 32'h0, {31'h0, busClaimOe});
    @(posedge clk);
    busHold <= 1'b0;
    waitOe(1'b0);
    cmp("grant out", 32'h1, {31'h0, grantChainOut});
    pollReq(4);
    cmp("request ctrl", 32'h11, q);
    apb(1'b1, dcr_pkg::OFF_REQ_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    @(negedge clk);
    cmp("bus claim", 32'h0, {31'h0, busClaimOe});
    cmp("grant out", {31'h0, grantChainIn}, {31'h0, grantChainOut});
    $display("done: bus");
    // resource won, released, then denied and retried
    apb(1'b1, dcr_pkg::OFF_REQ_CTRL, 32'h2);
    pollReq(5);
    cmp("request ctrl", 32'h22, q);
    cmp("resource out", 32'h1, {31'h0, resourceChainOut});
    apb(1'b1, dcr_pkg::OFF_REQ_CTRL, 32'h0);
    repeat (2) @(negedge clk);
    cmp("resource claim", 32'h0, {31'h0, resourceClaimOe});
    apb(1'b1, dcr_pkg::OFF_REQ_CTRL, 32'h2);
    waitOe(1'b1);
    @(posedge clk);
    resDeny <= 1'b1;
    pollReq(6);
    cmp("request ctrl", 32'h42, q);
    cmp("resource claim", 32'h0, {31'h0, resourceClaimOe});
    @(posedge clk);
    resDeny <= 1'b0;
    pollReq(5);
    cmp("request ctrl", 32'h62, q);
    apb(1'b1, dcr_pkg::OFF_REQ_CTRL, 32'h42);
    rd(dcr_pkg::OFF_REQ_CTRL, 32'h22, "request ctrl");
    $display("done: resource");
    wrap_up();
  end
endmodule
